// ===== rtl/tsr_consts.svh
/*
  Constants of the temperature sensor core: timing, register selectors,
  setup word field positions and reset values.
  Assumes inclusion by bare name from the scheduler and core design files.
*/
`ifndef TSR_CONSTS_SVH
`define TSR_CONSTS_SVH

`define TSR_CLK_PERIOD_NS 25
`define TSR_MS_NS 1000000
`define TSR_CONV_TIME_MS 32
`define TSR_PER_RATE0_MS 4000
`define TSR_PER_RATE1_MS 1000
`define TSR_PER_RATE2_MS 250
`define TSR_PER_RATE3_MS 125

`define TSR_SEL_TEMP 2'h0
`define TSR_SEL_SETUP 2'h1
`define TSR_SEL_LOWER 2'h2
`define TSR_SEL_UPPER 2'h3

`define TSR_FLD_CF_HI 12
`define TSR_FLD_CF_LO 11
`define TSR_FLD_SENSE 10
`define TSR_FLD_LATCH 9
`define TSR_FLD_SLEEP 8
`define TSR_FLD_RATE_HI 7
`define TSR_FLD_RATE_LO 6
`define TSR_FLD_FLAG 5

`define TSR_SETUP_RESET 16'h40A0
`define TSR_SETUP_WMASK 16'h9FD0
`define TSR_LOWER_RESET 12'h4B0
`define TSR_UPPER_RESET 12'h500

`endif

// ===== rtl/tsr_pkg.sv
/*
  Types of the temperature sensor core: serial engine states and the
  packed state records of the core and of the conversion scheduler.
  Assumes tsr_consts.svh is reachable on the include path.
*/
package tsr_pkg;

  typedef enum logic [2:0]
  {
    TSR_IDLE = 3'h0,
    TSR_ADDR = 3'h1,
    TSR_ACK_A = 3'h2,
    TSR_WR = 3'h3,
    TSR_ACK_W = 3'h4,
    TSR_RD = 3'h5,
    TSR_RACK = 3'h6
  } tsr_i2c_e;

  typedef struct packed
  {
    logic [23:0] div;
    logic [11:0] ms;
    logic [5:0] cms;
    logic busy;
    logic wake;
    logic done;
  } tsr_sched_s;

  typedef struct packed
  {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] addr_s;
    tsr_i2c_e st;
    logic [3:0] bcnt;
    logic rw;
    logic [7:0] sh;
    logic [15:0] dsh;
    logic [1:0] bidx;
    logic [7:0] msb;
    logic sda_oe;
    logic [1:0] ptr;
    logic [11:0] temp;
    logic [15:0] cfg;
    logic [11:0] lower;
    logic [11:0] upper;
    logic tripped;
    logic act;
    logic [2:0] fcnt;
  } tsr_core_s;

endpackage

// ===== rtl/tsr_conv_sched.sv
/*
  Conversion scheduler: millisecond timebase, conversion window and
  rate period. Starts a conversion right after reset and after wake-up.
  Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "tsr_consts.svh"

module tsr_conv_sched #(
  parameter int P_MS_CYCLES = `TSR_MS_NS / `TSR_CLK_PERIOD_NS
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_sleep,
  input wire logic [1:0] i_rate,
  output logic o_busy,
  output logic o_done
);

  tsr_pkg::tsr_sched_s s;
  tsr_pkg::tsr_sched_s next_s;
  logic tick;

  generate
    if (P_MS_CYCLES < 2 || P_MS_CYCLES > 16777215)
    begin : g_bad
      $error("P_MS_CYCLES out of range");
    end
  endgenerate

  function automatic logic [11:0] period_ms(input logic [1:0] r);
    case (r)
      2'h0: period_ms = 12'(`TSR_PER_RATE0_MS);
      2'h1: period_ms = 12'(`TSR_PER_RATE1_MS);
      2'h2: period_ms = 12'(`TSR_PER_RATE2_MS);
      default: period_ms = 12'(`TSR_PER_RATE3_MS);
    endcase
  endfunction

  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    tick = (s.div == 24'(P_MS_CYCLES - 1));
    next_s.div = tick ? 24'h000000 : s.div + 24'h000001;
    if (i_sleep)
    begin
      next_s.busy = 1'b0;
      next_s.ms = 12'h000;
      next_s.cms = 6'h00;
      next_s.wake = 1'b1;
    end
    else if (s.wake)
    begin
      next_s.wake = 1'b0;
      next_s.busy = 1'b1;
      next_s.ms = 12'h000;
      next_s.cms = 6'h00;
    end
    else if (tick)
    begin
      if (s.busy)
      begin
        next_s.cms = s.cms + 6'h01;
        if (s.cms == 6'(`TSR_CONV_TIME_MS - 1))
        begin
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
        end
      end
      if (s.ms >= period_ms(i_rate) - 12'h001)
      begin
        next_s.ms = 12'h000;
        next_s.busy = 1'b1;
        next_s.cms = 6'h00;
      end
      else
      begin
        next_s.ms = s.ms + 12'h001;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      s <= '0;
      s.wake <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign o_busy = s.busy;
  assign o_done = s.done;

  a_sleep_halts: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_sleep |=> !s.busy && !s.done)
    else $error("conversion active during sleep");

  c_conv_done: cover property (@(posedge i_clk) disable iff (!i_rstn) s.done);

endmodule

// ===== rtl/tsr_core.sv
/*
  Digital core of a serial-bus temperature sensor: two-wire slave,
  selector and data registers, threshold flag, alert pin and the
  conversion scheduler.
  Assumes SCL, SDA and the address strap are asynchronous pins, the
  converter result is stable on this clock, and pull-ups on the bus.
*/
// Functional notes
// - Eight-bit selector; only its two low bits store, others read zero.
// - Selector 0 temperature, 1 setup word, 2 lower, 3 upper threshold.
// - Temperature result is read-only; other three registers read and write.
// - Setup word moves most significant byte first, then least significant.
// - Setup word bits 3..0 and 14..13 are fixed and ignore writes.
// - Flag reads 1, goes 0 after upper faults, back 1 after lower faults.
// - Output sense inverts the encoding of the threshold flag.
// - In comparator mode the flag equals the alert pin level.
// - Rate field: 00 slowest, 01 one, 10 four, 11 eight per second.
// - Default conversion period after reset is 250 ms.
// - Temperature result changes only when a conversion completes.
// - A conversion starts at power-on; first result within 40 ms.
// - Conversions last 24 to 40 ms; standby until the next period.
// - Sleep bit set stops conversions at once; registers stay reachable.
// - Sleep bit cleared resumes continuous conversions at the set rate.
// - Latch mode bit: 0 comparator, 1 interrupt alert behaviour.
// - Comparator: alert active above upper, inactive below lower threshold.
// - Interrupt: alert fires on each crossing of either threshold.
// - Output sense 0 makes the alert pin active low, 1 active high.
// - Fault field sets consecutive count: 1, 2, 4 or 6 conversions.
// - Interrupt mode alert holds until any register read or setting the sleep bit clears it.
// - Temperatures are 12-bit two's complement in bits 15..4, low zero.
`timescale 1ns/1ps
`include "tsr_consts.svh"

module tsr_core #(
  parameter logic [6:0] P_DEV_ADDR = 7'h40,
  parameter int P_MS_CYCLES = `TSR_MS_NS / `TSR_CLK_PERIOD_NS
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_addr_sel,
  input wire logic [11:0] i_temp_sample,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_alert,
  output logic o_conv_busy
);

  tsr_pkg::tsr_core_s s;
  tsr_pkg::tsr_core_s next_s;
  logic conv_busy;
  logic conv_done;
  logic scl_r;
  logic scl_f;
  logic sda;
  logic start;
  logic stop;
  logic rd_evt;
  logic wr_commit;
  logic toggled;
  logic qual;
  logic flag;
  logic [15:0] wd;
  logic [7:0] sel_view;

  tsr_conv_sched #(
    .P_MS_CYCLES(P_MS_CYCLES)
  ) u_sched (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_sleep(s.cfg[`TSR_FLD_SLEEP]),
    .i_rate(s.cfg[`TSR_FLD_RATE_HI:`TSR_FLD_RATE_LO]),
    .o_busy(conv_busy),
    .o_done(conv_done)
  );

  function automatic logic [2:0] fault_n(input logic [1:0] f);
    case (f)
      2'h0: fault_n = 3'h1;
      2'h1: fault_n = 3'h2;
      2'h2: fault_n = 3'h4;
      default: fault_n = 3'h6;
    endcase
  endfunction

  // Word shown to the host for the selected register
  function automatic logic [15:0] rd_word(input tsr_pkg::tsr_core_s c, input logic f);
    case (c.ptr)
      `TSR_SEL_TEMP: rd_word = {c.temp, 4'h0};
      `TSR_SEL_SETUP: rd_word = {c.cfg[15:6], f, c.cfg[4:0]};
      `TSR_SEL_LOWER: rd_word = {c.lower, 4'h0};
      default: rd_word = {c.upper, 4'h0};
    endcase
  endfunction

  assign flag = ~(s.tripped ^ s.cfg[`TSR_FLD_SENSE]);
  assign sel_view = {6'h00, s.ptr};

  always_comb
  begin
    next_s = s;
    rd_evt = 1'b0;
    wr_commit = 1'b0;
    toggled = 1'b0;
    qual = 1'b0;
    wd = {s.msb, s.sh};
    next_s.scl_s = {s.scl_s[1:0], i_scl};
    next_s.sda_s = {s.sda_s[1:0], i_sda};
    next_s.addr_s = {s.addr_s[0], i_addr_sel};
    scl_r = s.scl_s[1] & ~s.scl_s[2];
    scl_f = ~s.scl_s[1] & s.scl_s[2];
    sda = s.sda_s[1];
    start = s.scl_s[1] & s.scl_s[2] & ~s.sda_s[1] & s.sda_s[2];
    stop = s.scl_s[1] & s.scl_s[2] & s.sda_s[1] & ~s.sda_s[2];

    if (start)
    begin
      next_s.st = tsr_pkg::TSR_ADDR;
      next_s.bcnt = 4'h0;
      next_s.sda_oe = 1'b0;
    end
    else if (stop)
    begin
      next_s.st = tsr_pkg::TSR_IDLE;
      next_s.sda_oe = 1'b0;
    end
    else
    begin
      case (s.st)
        tsr_pkg::TSR_ADDR:
        begin
          if (scl_r)
          begin
            next_s.sh = {s.sh[6:0], sda};
            next_s.bcnt = s.bcnt + 4'h1;
          end
          else if (scl_f && s.bcnt == 4'h8)
          begin
            if (s.sh[7:1] == {P_DEV_ADDR[6:1], s.addr_s[1]})
            begin
              next_s.st = tsr_pkg::TSR_ACK_A;
              next_s.sda_oe = 1'b1;
              next_s.rw = s.sh[0];
              next_s.bidx = 2'h0;
              if (s.sh[0])
              begin
                next_s.dsh = rd_word(s, flag);
                rd_evt = 1'b1;
              end
            end
            else
            begin
              next_s.st = tsr_pkg::TSR_IDLE;
            end
          end
        end
        tsr_pkg::TSR_ACK_A:
        begin
          if (scl_f)
          begin
            next_s.bcnt = 4'h0;
            next_s.st = s.rw ? tsr_pkg::TSR_RD : tsr_pkg::TSR_WR;
            next_s.sda_oe = s.rw & ~s.dsh[15];
          end
        end
        tsr_pkg::TSR_WR:
        begin
          if (scl_r)
          begin
            next_s.sh = {s.sh[6:0], sda};
            next_s.bcnt = s.bcnt + 4'h1;
          end
          else if (scl_f && s.bcnt == 4'h8)
          begin
            next_s.st = tsr_pkg::TSR_ACK_W;
            next_s.sda_oe = 1'b1;
            case (s.bidx)
              2'h0:
              begin
                next_s.ptr = s.sh[1:0];
                next_s.bidx = 2'h1;
              end
              2'h1:
              begin
                next_s.msb = s.sh;
                next_s.bidx = 2'h2;
              end
              default:
              begin
                wr_commit = 1'b1;
                next_s.bidx = 2'h1;
              end
            endcase
          end
        end
        tsr_pkg::TSR_ACK_W:
        begin
          if (scl_f)
          begin
            next_s.st = tsr_pkg::TSR_WR;
            next_s.sda_oe = 1'b0;
            next_s.bcnt = 4'h0;
          end
        end
        tsr_pkg::TSR_RD:
        begin
          if (scl_r)
          begin
            next_s.bcnt = s.bcnt + 4'h1;
          end
          else if (scl_f)
          begin
            next_s.dsh = {s.dsh[14:0], 1'b0};
            if (s.bcnt == 4'h8)
            begin
              next_s.st = tsr_pkg::TSR_RACK;
              next_s.sda_oe = 1'b0;
            end
            else
            begin
              next_s.sda_oe = ~s.dsh[14];
            end
          end
        end
        tsr_pkg::TSR_RACK:
        begin
          if (scl_r && sda)
          begin
            next_s.st = tsr_pkg::TSR_IDLE;
          end
          else if (scl_f)
          begin
            next_s.st = tsr_pkg::TSR_RD;
            next_s.bcnt = 4'h0;
            next_s.sda_oe = ~s.dsh[15];
          end
        end
        default:
        begin
          next_s.st = tsr_pkg::TSR_IDLE;
        end
      endcase
    end

    if (wr_commit)
    begin
      case (s.ptr)
        `TSR_SEL_SETUP:
          next_s.cfg = (s.cfg & ~`TSR_SETUP_WMASK) | (wd & `TSR_SETUP_WMASK);
        `TSR_SEL_LOWER: next_s.lower = wd[15:4];
        `TSR_SEL_UPPER: next_s.upper = wd[15:4];
        default: next_s.temp = s.temp;
      endcase
    end

    if (conv_done)
    begin
      next_s.temp = i_temp_sample;
      if (s.tripped)
      begin
        qual = $signed(i_temp_sample) <= $signed(s.lower);
      end
      else
      begin
        qual = $signed(i_temp_sample) >= $signed(s.upper);
      end
      if (qual)
      begin
        if (s.fcnt + 3'h1 >= fault_n(s.cfg[`TSR_FLD_CF_HI:`TSR_FLD_CF_LO]))
        begin
          next_s.tripped = ~s.tripped;
          next_s.fcnt = 3'h0;
          toggled = 1'b1;
        end
        else
        begin
          next_s.fcnt = s.fcnt + 3'h1;
        end
      end
      else
      begin
        next_s.fcnt = 3'h0;
      end
    end

    // Clears first so that a crossing in the same cycle still sets
    if (rd_evt || s.cfg[`TSR_FLD_SLEEP])
    begin
      next_s.act = 1'b0;
    end
    if (toggled)
    begin
      next_s.act = 1'b1;
    end
    if (!next_s.cfg[`TSR_FLD_LATCH])
    begin
      next_s.act = next_s.tripped;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      s <= '0;
      s.scl_s <= 3'h7;
      s.sda_s <= 3'h7;
      s.st <= tsr_pkg::TSR_IDLE;
      s.cfg <= `TSR_SETUP_RESET;
      s.lower <= `TSR_LOWER_RESET;
      s.upper <= `TSR_UPPER_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign o_sda_o = 1'b0;
  assign o_sda_oe = s.sda_oe;
  assign o_alert = s.act ? s.cfg[`TSR_FLD_SENSE] : ~s.cfg[`TSR_FLD_SENSE];
  assign o_conv_busy = conv_busy;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  a_sel_upper_zero: assert property (sel_view[7:2] == 6'h00)
    else $error("selector upper bits not zero");

  a_temp_read_only: assert property (
    wr_commit && s.ptr == `TSR_SEL_TEMP && !conv_done |=> $stable(s.temp))
    else $error("temperature changed by host write");

  a_setup_fixed_bits: assert property (
    s.cfg[3:0] == 4'h0 && s.cfg[14:13] == 2'b10)
    else $error("fixed setup bits altered");

  a_temp_hold: assert property (!conv_done |=> $stable(s.temp))
    else $error("temperature changed without conversion");

  a_flag_pin_match: assert property (
    !s.cfg[`TSR_FLD_LATCH] |-> o_alert == flag)
    else $error("flag and alert pin differ in comparator mode");

  a_pin_sense: assert property (
    s.act |-> o_alert == s.cfg[`TSR_FLD_SENSE])
    else $error("alert pin level does not follow output sense");

  a_read_clears: assert property (
    rd_evt && s.cfg[`TSR_FLD_LATCH] && !toggled ##1 s.cfg[`TSR_FLD_LATCH] |-> !s.act)
    else $error("interrupt alert not cleared by read");

  a_fault_restart: assert property (
    conv_done && !qual |=> s.fcnt == 3'h0)
    else $error("fault count kept after non-qualifying result");

  a_sleep_quiet: assert property (
    s.cfg[`TSR_FLD_SLEEP] ##1 s.cfg[`TSR_FLD_SLEEP] |-> !conv_busy && !conv_done)
    else $error("conversion during sleep");

  c_alert_trip: cover property (toggled && !s.tripped);
  c_int_clear: cover property (rd_evt && s.act && s.cfg[`TSR_FLD_LATCH]);
  c_setup_write: cover property (wr_commit && s.ptr == `TSR_SEL_SETUP);

endmodule

// ===== test/tsr_i2c_host.sv
/*
  Two-wire bus master model: start, stop, byte write and byte read.
  Assumes the bench resolves SDA with a pull-up from both drivers.
*/
`timescale 1ns/1ps

module tsr_i2c_host (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic q(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // Works as first and as repeated start
  task automatic start();
    q(2);
    o_sda_low = 1'b0;
    q(2);
    o_scl = 1'b1;
    q(4);
    o_sda_low = 1'b1;
    q(4);
    o_scl = 1'b0;
  endtask

  task automatic stop();
    q(2);
    o_sda_low = 1'b1;
    q(2);
    o_scl = 1'b1;
    q(4);
    o_sda_low = 1'b0;
    q(4);
  endtask

  task automatic wbit(input logic b);
    q(2);
    o_sda_low = ~b;
    q(2);
    o_scl = 1'b1;
    q(4);
    o_scl = 1'b0;
  endtask

  task automatic rbit(output logic b);
    q(2);
    o_sda_low = 1'b0;
    q(2);
    o_scl = 1'b1;
    q(2);
    b = i_sda;
    q(2);
    o_scl = 1'b0;
  endtask

  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      wbit(v[i]);
    rbit(b);
    ack = ~b;
  endtask

  task automatic rbyte(output logic [7:0] v, input logic ack);
    for (int i = 7; i >= 0; i--)
      rbit(v[i]);
    wbit(~ack);
  endtask
endmodule

// ===== test/tb_top.sv
/*
  Self-checking bench of the sensor core: register access over the bus
  model, conversion timing, threshold flag and alert pin.
  Assumes tsr_core and the bus master model are compiled before it.
*/
`timescale 1ns/1ps

module tb_top;
  localparam int P_MS = 4;
  logic i_clk, i_rstn, i_addr_sel;
  logic [11:0] i_temp_sample;
  logic o_sda_o, o_sda_oe, o_alert, o_conv_busy;
  logic scl, sda_low, sda;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  int c;
  logic [1:0] rates [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
  int per [4] = '{500, 1000, 4000, 16000};

  assign sda = (o_sda_oe ? o_sda_o : 1'b1) & ~sda_low;

  tsr_core #(.P_DEV_ADDR(7'h40), .P_MS_CYCLES(P_MS)) dut (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_scl(scl), .i_sda(sda), .i_addr_sel(i_addr_sel), .i_temp_sample(i_temp_sample),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_alert(o_alert), .o_conv_busy(o_conv_busy));

  tsr_i2c_host host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] sel, input logic [15:0] v, input logic data);
    logic a0, a1, a2, a3;
    a2 = 1'b1;
    a3 = 1'b1;
    host.start();
    host.wbyte(8'h82, a0);
    host.wbyte(sel, a1);
    if (data)
    begin
      host.wbyte(v[15:8], a2);
      host.wbyte(v[7:0], a3);
    end
    host.stop();
    check({12'h000, a0, a1, a2, a3}, 16'h000F);
  endtask

  task automatic rdchk(input logic [7:0] sel, input logic [15:0] exp);
    logic a;
    logic [15:0] v;
    wr(sel, 16'h0000, 1'b0);
    host.start();
    host.wbyte(8'h83, a);
    host.rbyte(v[15:8], 1'b1);
    host.rbyte(v[7:0], 1'b0);
    host.stop();
    check(v, exp);
    check({15'h0000, a}, 16'h0001);
  endtask

  task automatic wait_conv();
    int n;
    n = 0;
    while (o_conv_busy !== 1'b1 && n < 20000)
    begin
      @(negedge i_clk);
      n++;
    end
    while (o_conv_busy !== 1'b0 && n < 20000)
    begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 20000)
      mismatches++;
    repeat (3) @(negedge i_clk);
  endtask

  // Cycles from one conversion start to the next
  task automatic period(output int n);
    n = 0;
    while (o_conv_busy !== 1'b1)
      @(negedge i_clk);
    while (o_conv_busy !== 1'b0)
    begin
      @(negedge i_clk);
      n++;
    end
    while (o_conv_busy !== 1'b1)
    begin
      @(negedge i_clk);
      n++;
    end
  endtask

  initial
  begin
    i_rstn = 1'b0;
    i_addr_sel = 1'b1;
    i_temp_sample = 12'h190;
    repeat (20) @(negedge i_clk);
    i_rstn = 1'b1;
    c = 0;
    repeat (3) @(negedge i_clk);
    check(o_conv_busy, 16'h0001);
    while (o_conv_busy === 1'b1 && c < 400)
    begin
      @(negedge i_clk);
      c++;
    end
    check(c >= 94 && c <= 160, 16'h0001);
    rdchk(8'h01, 16'h40A0);
    rdchk(8'h02, 16'h4B00);
    rdchk(8'h03, 16'h5000);
    rdchk(8'h00, 16'h1900);
    wr(8'h00, 16'h1230, 1'b1);
    rdchk(8'h00, 16'h1900);
    rdchk(8'hFE, 16'h4B00);
    // Comparator mode, one fault
    wr(8'h03, 16'h2000, 1'b1);
    wr(8'h02, 16'h1000, 1'b1);
    i_temp_sample = 12'h300;
    wait_conv();
    wait_conv();
    check(o_alert, 16'h0000);
    rdchk(8'h01, 16'h4080);
    i_temp_sample = 12'h0F0;
    wait_conv();
    wait_conv();
    check(o_alert, 16'h0001);
    rdchk(8'h01, 16'h40A0);
    // Two consecutive faults, broken run
    wr(8'h01, 16'h0880, 1'b1);
    i_temp_sample = 12'h300;
    wait_conv();
    check(o_alert, 16'h0001);
    i_temp_sample = 12'h0F0;
    wait_conv();
    i_temp_sample = 12'h300;
    wait_conv();
    check(o_alert, 16'h0001);
    wait_conv();
    check(o_alert, 16'h0000);
    i_temp_sample = 12'h0F0;
    wait_conv();
    wait_conv();
    // Four faults, output sense high
    wr(8'h01, 16'h1480, 1'b1);
    check(o_alert, 16'h0000);
    i_temp_sample = 12'h300;
    repeat (3) wait_conv();
    check(o_alert, 16'h0000);
    wait_conv();
    check(o_alert, 16'h0001);
    rdchk(8'h01, 16'h54A0);
    i_temp_sample = 12'h0F0;
    wr(8'h01, 16'h0080, 1'b1);
    wait_conv();
    check(o_alert, 16'h0001);
    // Interrupt mode
    wr(8'h01, 16'h0280, 1'b1);
    i_temp_sample = 12'h300;
    wait_conv();
    wait_conv();
    check(o_alert, 16'h0000);
    rdchk(8'h00, 16'h3000);
    check(o_alert, 16'h0001);
    wait_conv();
    check(o_alert, 16'h0001);
    i_temp_sample = 12'h0F0;
    wait_conv();
    wait_conv();
    check(o_alert, 16'h0000);
    wr(8'h01, 16'h0380, 1'b1);
    check({o_alert, o_conv_busy}, 16'h0002);
    i_temp_sample = 12'h050;
    repeat (1200) @(negedge i_clk);
    check(o_conv_busy, 16'h0000);
    rdchk(8'h00, 16'h0F00);
    wr(8'h01, 16'h0280, 1'b1);
    check(o_conv_busy, 16'h0001);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h01, {8'h01, rates[i], 6'h00}, 1'b1);
      wr(8'h01, {8'h00, rates[i], 6'h00}, 1'b1);
      period(c);
      period(c);
      check(c >= per[i] - 3 && c <= per[i] + 3, 16'h0001);
    end
    wr(8'h01, 16'hFFEF, 1'b1);
    rdchk(8'h01, 16'hDFC0);
    check({o_alert, o_conv_busy}, 16'h0000);
    wrap_up();
  end
endmodule
